/* File: rtl/dfg_pkg.sv */
// dfg_pkg: constants, field layouts and carrier types of the dead-time fault gate
// assumes an AXI4-Lite master with 32-bit data and the lock register offsets below
package dfg_pkg;

	localparam int DFG_ADDR_W = 8;
	localparam int DFG_NUM_CH = 12;

	// register byte offsets
	localparam logic [7:0] DFG_OFF_FAULT_CONFIG = 8'hA8;
	localparam logic [7:0] DFG_OFF_OUT_GEN_EN = 8'hAC;
	localparam logic [7:0] DFG_OFF_FAULT_FLAGS = 8'hB0;
	localparam logic [7:0] DFG_OFF_FAULT_CLEAR = 8'hB4;
	localparam logic [7:0] DFG_OFF_CONFIG_LOCK = 8'hB8;
	localparam logic [7:0] DFG_OFF_IRQ_MASK = 8'hBC;

	// fault configuration fields
	localparam int DFG_EV0_SEL_LSB = 0;
	localparam int DFG_EV1_SEL_LSB = 8;
	localparam int DFG_ACTION_LSB = 16;
	localparam int DFG_EV0_EN_BIT = 24;
	localparam int DFG_EV1_EN_BIT = 25;
	localparam int DFG_DBG_EN_BIT = 26;
	localparam int DFG_LOCKUP_EN_BIT = 27;

	// fault flag positions (also clear and mask positions)
	localparam int DFG_EV0_FLAG_BIT = 0;
	localparam int DFG_EV1_FLAG_BIT = 1;
	localparam int DFG_DBG_FLAG_BIT = 2;
	localparam int DFG_LOCKUP_FLAG_BIT = 3;

	localparam logic [15:0] DFG_UNLOCK_KEY = 16'hCE80;

	// reset values
	localparam logic [3:0] DFG_RST_SEL = 4'h0;
	localparam logic [1:0] DFG_RST_ACTION = 2'h0;
	localparam logic [5:0] DFG_RST_OUT_GEN_EN = 6'h00;
	localparam logic [3:0] DFG_RST_FLAGS = 4'h0;
	localparam logic [3:0] DFG_RST_MASK = 4'h0;

	localparam logic [1:0] DFG_RESP_OKAY = 2'h0;
	localparam logic [1:0] DFG_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		DFG_ACT_NONE,
		DFG_ACT_INACTIVE,
		DFG_ACT_CLEAR,
		DFG_ACT_TRISTATE
	} dfg_action_type;

	typedef struct packed {
		logic lockup_fault_enable;
		logic debugger_fault_enable;
		logic event_fault1_enable;
		logic event_fault0_enable;
		dfg_action_type fault_action;
		logic [3:0] event_fault1_channel_select;
		logic [3:0] event_fault0_channel_select;
	} dfg_fault_config_type;

	// three primary then three complementary lines
	typedef struct packed {
		logic [2:0] complementary;
		logic [2:0] primary;
	} dfg_out_group_type;

	typedef struct packed {
		logic lockup;
		logic debugger;
		logic event_fault1;
		logic event_fault0;
	} dfg_flags_type;

endpackage : dfg_pkg

/* File: rtl/dfg_gate.sv */
// dfg_gate: fault source selection, sticky fault flags and output gating
// assumes lockup, halt and event channels come from other clock domains; dead-time lines share aclk
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// (RULE1) event fault sources 0 and 1 only count when enable bits 24 and 25 set.
// (RULE2) action field 17:16 picks none, inactive level, cleared, or high impedance outputs.
// (RULE3) bits 3:0 pick event channel 0..11 for source 0, reset 0.
// (RULE4) bits 11:8 pick event channel 0..11 for source 1.
// (RULE5) enable bits 0..2 gate the three primary outputs.
// (RULE6) enable bits 3..5 gate complementary outputs; all six reset to 0.
// (RULE7) lockup flag bit 3 sets on core lockup while enable bit 27 set.
// (RULE8) debugger flag bit 2 sets on debugger halt while enable bit 26 set.
// (RULE9) flag bit 1 sets on selected event source 1 while enabled.
// (RULE10) flag bit 0 sets on selected event source 0 while enabled; flags reset 0.
// (RULE11) writing 1 to clear bit 3 clears lockup flag; zeros do nothing.
// (RULE12) writing 1 to clear bit 2 clears only the debugger flag.
// (RULE13) writing 1 to clear bit 1 clears only event source 1 flag.
// (RULE14) writing 1 to clear bit 0 clears event source 0 flag.
// (RULE15) fault configuration ignores writes while locked; key unlocks, other values lock.
// (RULE16) fault action stays applied until every set flag is cleared.
// (RULE17) software writes zero to reserved bits of these registers.
module dfg_gate #(
	parameter int NUM_CH = dfg_pkg::DFG_NUM_CH
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [dfg_pkg::DFG_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [dfg_pkg::DFG_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic core_lockup,
	input wire logic debugger_halt,
	input wire logic [NUM_CH-1:0] event_channel_network,
	input wire dfg_pkg::dfg_out_group_type deadtime_in,
	input wire logic inactive_level,
	output dfg_pkg::dfg_out_group_type gated_out,
	output dfg_pkg::dfg_out_group_type gated_out_en,
	output logic config_locked,
	output logic irq
);
	import dfg_pkg::*;

	initial begin
		if (NUM_CH < 1 || NUM_CH > 16) begin
			$error("dfg_gate: NUM_CH must lie in 1..16");
		end
	end

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic aw_held;
		logic [DFG_ADDR_W-1:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		dfg_fault_config_type cfg;
		dfg_out_group_type gen_en;
		dfg_flags_type flags;
		logic [3:0] irq_mask;
		logic locked;
		logic [NUM_CH-1:0] ev_meta;
		logic [NUM_CH-1:0] ev_sync;
		logic [1:0] lockup_meta;
		logic [1:0] halt_meta;
		dfg_out_group_type out;
		dfg_out_group_type out_en;
		logic irq;
	} dfg_state_type;

	dfg_state_type state;
	dfg_state_type next_state;

	logic ev0_raw;
	logic ev1_raw;
	logic [3:0] set_flags;
	logic [3:0] clr_flags;
	logic [31:0] read_word;
	logic read_ok;
	logic write_ok;
	logic do_write;
	logic [DFG_ADDR_W-1:0] waddr;
	logic [31:0] wdata;
	logic fault_active;

	assign s_axi_awready = state.awready;
	assign s_axi_wready = state.wready;
	assign s_axi_bvalid = state.bvalid;
	assign s_axi_bresp = state.bresp;
	assign s_axi_arready = state.arready;
	assign s_axi_rvalid = state.rvalid;
	assign s_axi_rresp = state.rresp;
	assign s_axi_rdata = state.rdata;
	assign gated_out = state.out;
	assign gated_out_en = state.out_en;
	assign config_locked = state.locked;
	assign irq = state.irq;

	always_comb begin
		next_state = state;
		// synchroniser stage two reads stage one only
		next_state.ev_meta = event_channel_network;
		next_state.ev_sync = state.ev_meta;
		next_state.lockup_meta = {state.lockup_meta[0], core_lockup};
		next_state.halt_meta = {state.halt_meta[0], debugger_halt};

		// (RULE3) source 0 channel pick
		ev0_raw = (32'(state.cfg.event_fault0_channel_select) < NUM_CH) ?
			state.ev_sync[state.cfg.event_fault0_channel_select] : 1'b0;
		// (RULE4) source 1 channel pick
		ev1_raw = (32'(state.cfg.event_fault1_channel_select) < NUM_CH) ?
			state.ev_sync[state.cfg.event_fault1_channel_select] : 1'b0;

		// (RULE1) (RULE9) (RULE10) event sources gated
		set_flags[DFG_EV0_FLAG_BIT] = ev0_raw & state.cfg.event_fault0_enable;
		set_flags[DFG_EV1_FLAG_BIT] = ev1_raw & state.cfg.event_fault1_enable;
		// (RULE8) debugger source gated
		set_flags[DFG_DBG_FLAG_BIT] = state.halt_meta[1] & state.cfg.debugger_fault_enable;
		// (RULE7) lockup source gated
		set_flags[DFG_LOCKUP_FLAG_BIT] = state.lockup_meta[1] & state.cfg.lockup_fault_enable;

		// write channel capture, either order
		if (s_axi_awvalid && state.awready) begin
			next_state.aw_held = 1'b1;
			next_state.aw_addr = s_axi_awaddr;
			next_state.awready = 1'b0;
		end
		if (s_axi_wvalid && state.wready) begin
			next_state.w_held = 1'b1;
			next_state.w_data = s_axi_wdata;
			next_state.w_strb = s_axi_wstrb;
			next_state.wready = 1'b0;
		end
		do_write = state.aw_held && state.w_held && !state.bvalid;
		waddr = state.aw_addr;
		wdata = state.w_data;
		write_ok = 1'b1;
		clr_flags = 4'h0;
		if (do_write) begin
			next_state.aw_held = 1'b0;
			next_state.w_held = 1'b0;
			next_state.bvalid = 1'b1;
			case (waddr)
				DFG_OFF_FAULT_CONFIG: begin
					// (RULE15) locked writes dropped
					if (!state.locked && state.w_strb == 4'hF) begin
						next_state.cfg.event_fault0_channel_select = wdata[DFG_EV0_SEL_LSB +: 4];
						next_state.cfg.event_fault1_channel_select = wdata[DFG_EV1_SEL_LSB +: 4];
						next_state.cfg.fault_action = dfg_action_type'(wdata[DFG_ACTION_LSB +: 2]);
						next_state.cfg.event_fault0_enable = wdata[DFG_EV0_EN_BIT];
						next_state.cfg.event_fault1_enable = wdata[DFG_EV1_EN_BIT];
						next_state.cfg.debugger_fault_enable = wdata[DFG_DBG_EN_BIT];
						next_state.cfg.lockup_fault_enable = wdata[DFG_LOCKUP_EN_BIT];
					end
				end
				DFG_OFF_OUT_GEN_EN: begin
					// (RULE5) primary enables stored
					if (state.w_strb[0]) begin
						next_state.gen_en = wdata[5:0];
					end
				end
				DFG_OFF_FAULT_CLEAR: begin
					// (RULE11) one bits clear flags
					if (state.w_strb[0]) begin
						clr_flags = wdata[3:0];
					end
				end
				DFG_OFF_CONFIG_LOCK: begin
					// (RULE15) key unlocks, else lock
					if (state.w_strb[1:0] == 2'h3) begin
						next_state.locked = (wdata[15:0] != DFG_UNLOCK_KEY);
					end
				end
				DFG_OFF_IRQ_MASK: begin
					if (state.w_strb[0]) begin
						next_state.irq_mask = wdata[3:0];
					end
				end
				DFG_OFF_FAULT_FLAGS: begin
					write_ok = 1'b1;
				end
				default: begin
					write_ok = 1'b0;
				end
			endcase
			next_state.bresp = write_ok ? DFG_RESP_OKAY : DFG_RESP_SLVERR;
		end
		if (state.bvalid && s_axi_bready) begin
			next_state.bvalid = 1'b0;
			next_state.awready = 1'b1;
			next_state.wready = 1'b1;
		end

		// (RULE12) per-bit clear, set wins over clear
		// (RULE13) other flags untouched
		// (RULE14) event source 0 clear
		next_state.flags = (state.flags & ~dfg_flags_type'(clr_flags)) | dfg_flags_type'(set_flags);

		// read channel
		read_ok = 1'b1;
		case (s_axi_araddr)
			DFG_OFF_FAULT_CONFIG: read_word = {4'h0, state.cfg.lockup_fault_enable,
				state.cfg.debugger_fault_enable, state.cfg.event_fault1_enable,
				state.cfg.event_fault0_enable, 6'h00, state.cfg.fault_action, 4'h0,
				state.cfg.event_fault1_channel_select, 4'h0,
				state.cfg.event_fault0_channel_select};
			DFG_OFF_OUT_GEN_EN: read_word = {26'h0, state.gen_en};
			// flags visible to software
			DFG_OFF_FAULT_FLAGS: read_word = {28'h0, state.flags};
			DFG_OFF_FAULT_CLEAR: read_word = 32'h0;
			DFG_OFF_CONFIG_LOCK: read_word = {31'h0, state.locked};
			DFG_OFF_IRQ_MASK: read_word = {28'h0, state.irq_mask};
			default: begin
				read_word = 32'h0;
				read_ok = 1'b0;
			end
		endcase
		if (s_axi_arvalid && state.arready) begin
			next_state.arready = 1'b0;
			next_state.rvalid = 1'b1;
			next_state.rdata = read_word;
			next_state.rresp = read_ok ? DFG_RESP_OKAY : DFG_RESP_SLVERR;
		end
		if (state.rvalid && s_axi_rready) begin
			next_state.rvalid = 1'b0;
			next_state.arready = 1'b1;
		end

		// (RULE16) action held while any flag set
		fault_active = |state.flags;
		// (RULE6) output gating per line
		next_state.out = deadtime_in & state.gen_en;
		next_state.out_en = state.gen_en;
		if (fault_active) begin
			// (RULE2) fault action select
			case (state.cfg.fault_action)
				DFG_ACT_INACTIVE: next_state.out = {6{inactive_level}} & state.gen_en;
				DFG_ACT_CLEAR: next_state.out = 6'h00;
				DFG_ACT_TRISTATE: begin
					next_state.out = 6'h00;
					next_state.out_en = 6'h00;
				end
				default: next_state.out = deadtime_in & state.gen_en;
			endcase
		end

		// interrupt from unmasked flags
		next_state.irq = |(next_state.flags & state.irq_mask);

		// (RULE10) flags reset to zero
		if (!aresetn) begin
			next_state = '0;
			next_state.awready = 1'b1;
			next_state.wready = 1'b1;
			next_state.arready = 1'b1;
			next_state.cfg.event_fault0_channel_select = DFG_RST_SEL;
			next_state.cfg.event_fault1_channel_select = DFG_RST_SEL;
			next_state.cfg.fault_action = dfg_action_type'(DFG_RST_ACTION);
			next_state.gen_en = DFG_RST_OUT_GEN_EN;
			next_state.flags = DFG_RST_FLAGS;
			next_state.irq_mask = DFG_RST_MASK;
		end
	end

	always_ff @(posedge aclk) begin
		state <= next_state;
	end

endmodule // dfg_gate

`default_nettype wire

/* File: tb/dfg_src_model.sv */
// dfg_src_model: fault sources on the far side (event channels, lockup, halt)
// assumes the bench requests levels on fault_req; LAG sets how slowly they appear
`timescale 1ns/1ps
`default_nettype none
module dfg_src_model #(
	parameter int LAG = 2
) (
	input wire logic aclk,
	input wire logic [13:0] fault_req,
	output logic core_lockup,
	output logic debugger_halt,
	output logic [11:0] event_channel_network
);
	logic [13:0] pipe [LAG];
	always_ff @(posedge aclk) begin
		pipe[0] <= fault_req;
		for (int k = 1; k < LAG; k++) begin
			pipe[k] <= pipe[k-1];
		end
	end
	// bit 13 lockup, bit 12 halt, 11:0 channels
	assign {core_lockup, debugger_halt, event_channel_network} = pipe[LAG-1];
endmodule // dfg_src_model
`default_nettype wire

/* File: tb/dfg_gate_chk.sv */
// dfg_gate_chk: port-level assertions for the fault gate
// assumes a master with one write and one read in flight
`timescale 1ns/1ps
`default_nettype none
module dfg_gate_chk
	import dfg_pkg::*;
#(
	parameter int NUM_CH = 12
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic core_lockup,
	input wire logic debugger_halt,
	input wire logic [NUM_CH-1:0] event_channel_network,
	input wire dfg_pkg::dfg_out_group_type gated_out_en,
	input wire logic config_locked,
	input wire logic irq
);
	default clocking dc @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic w_any;
	assign w_any = (s_axi_wvalid && s_axi_wready) || (s_axi_awvalid && s_axi_awready);

	a_reset_idle: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid
		&& !irq && !config_locked && gated_out_en == 6'h00) else $error("not idle after reset");
	a_wr_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid) else $error("write response late");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
	a_busy_ready: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("ready while busy");
	a_rd_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read response late");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_unmapped_rd: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'hC0
		|=> s_axi_rresp == DFG_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
	a_irq_cause: assert property ($rose(irq) |-> $past(w_any, 3)
		|| $past(core_lockup || debugger_halt || (|event_channel_network), 2)) else $error("irq without fault");
	a_irq_sticky: assert property (irq && !$past(w_any) && !$past(w_any, 2) |=> irq)
		else $error("flag lost without clear");
	a_lock_cause: assert property ($changed(config_locked) |-> $past(w_any, 2))
		else $error("lock moved alone");
	c_irq: cover property ($rose(irq));
	c_lock: cover property ($rose(config_locked));
	c_slverr: cover property (s_axi_rvalid && s_axi_rresp == DFG_RESP_SLVERR);
endmodule // dfg_gate_chk
bind dfg_gate dfg_gate_chk #(.NUM_CH(NUM_CH)) chk (.*);
`default_nettype wire

/* File: tb/test_deadtime_fault_output_gate.sv */
// test_deadtime_fault_output_gate: register-level bench for the fault gate
// assumes the source model drives the lockup, halt and event inputs
`timescale 1ns/1ps
`default_nettype none
module test_deadtime_fault_output_gate
	import dfg_pkg::*;
;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, core_lockup;
	logic debugger_halt, inactive_level, config_locked, irq;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_val, cfg;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
	logic [11:0] event_channel_network;
	logic [13:0] fault_req;
	dfg_out_group_type deadtime_in, gated_out, gated_out_en;
	int err_count, tests_run, cyc;
	logic [5:0] eo [4] = '{6'h2A, 6'h3F, 6'h00, 6'h00};
	logic [5:0] ee [4] = '{6'h3F, 6'h3F, 6'h3F, 6'h00};

	dfg_gate dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .core_lockup, .debugger_halt, .event_channel_network, .deadtime_in,
		.inactive_level, .gated_out, .gated_out_en, .config_locked, .irq);
	dfg_src_model #(.LAG(2)) src (.aclk, .fault_req, .core_lockup, .debugger_halt,
		.event_channel_network);

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) begin
				wr_resp = s_axi_bresp;
				break;
			end
			if (s_axi_bvalid) s_axi_bready <= 1'b1;
		end
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) break;
			if (s_axi_rvalid) s_axi_rready <= 1'b1;
		end
		rd_val = s_axi_rdata;
		rd_resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
		chk(rd_val, e);
	endtask

	task automatic pulse(input logic [13:0] r);
		fault_req <= r;
		repeat (6) @(posedge aclk);
		fault_req <= 14'h0;
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count++;
			results();
		end
	end

	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, fault_req, inactive_level} = '0;
		s_axi_wstrb = 4'hF;
		deadtime_in = 6'h2A;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rc(DFG_OFF_OUT_GEN_EN, 32'h0);
		rc(DFG_OFF_FAULT_CONFIG, 32'h0);
		rc(DFG_OFF_FAULT_FLAGS, 32'h0);
		rc(8'hC0, 32'h0);
		chk(rd_resp, DFG_RESP_SLVERR);
		pulse(14'h3FFF);
		rc(DFG_OFF_FAULT_FLAGS, 32'h0);
		inactive_level <= 1'b1;
		wr(DFG_OFF_IRQ_MASK, 32'hF);
		wr(DFG_OFF_OUT_GEN_EN, 32'h0F);
		chk(gated_out, 6'h0A);
		chk(gated_out_en, 6'h0F);
		wr(DFG_OFF_OUT_GEN_EN, 32'h3F);
		for (int i = 0; i < 4; i++) begin
			cfg = 32'h0000_050B | (32'h1 << (24 + i)) | (32'(i) << 16);
			wr(DFG_OFF_FAULT_CONFIG, cfg);
			rc(DFG_OFF_FAULT_CONFIG, cfg);
			pulse(i == 0 ? 14'h0800 : i == 1 ? 14'h0020 : 14'h1 << (10 + i));
			rc(DFG_OFF_FAULT_FLAGS, 32'h1 << i);
			chk(irq, 1'b1);
			wr(DFG_OFF_FAULT_CLEAR, 32'h0);
			rc(DFG_OFF_FAULT_FLAGS, 32'h1 << i);
			chk(gated_out, eo[i]);
			chk(gated_out_en, ee[i]);
			wr(DFG_OFF_FAULT_CLEAR, 32'h1 << i);
			rc(DFG_OFF_FAULT_FLAGS, 32'h0);
			chk(gated_out, 6'h2A);
			chk(irq, 1'b0);
		end
		wr(DFG_OFF_FAULT_CONFIG, 32'h0F00_050B);
		pulse(14'h1800);
		rc(DFG_OFF_FAULT_FLAGS, 32'h5);
		wr(DFG_OFF_FAULT_CLEAR, 32'h4);
		rc(DFG_OFF_FAULT_FLAGS, 32'h1);
		wr(DFG_OFF_IRQ_MASK, 32'h0);
		chk(irq, 1'b0);
		wr(DFG_OFF_IRQ_MASK, 32'hF);
		chk(irq, 1'b1);
		wr(DFG_OFF_FAULT_CLEAR, 32'h1);
		rc(DFG_OFF_FAULT_FLAGS, 32'h0);
		wr(DFG_OFF_CONFIG_LOCK, 32'h0);
		rc(DFG_OFF_CONFIG_LOCK, 32'h1);
		chk(config_locked, 1'b1);
		wr(DFG_OFF_FAULT_CONFIG, 32'h0);
		chk(wr_resp, DFG_RESP_OKAY);
		rc(DFG_OFF_FAULT_CONFIG, 32'h0F00_050B);
		wr(8'hC0, 32'h0);
		chk(wr_resp, DFG_RESP_SLVERR);
		wr(DFG_OFF_CONFIG_LOCK, 32'h0000_CE80);
		rc(DFG_OFF_CONFIG_LOCK, 32'h0);
		results();
	end
endmodule // test_deadtime_fault_output_gate
`default_nettype wire
